// ==== rtl/frame_signature_analyzer.sv ====
/*
 * signature analyzer: crc-16 over one colour component of one frame, apb control/status.
 * assumes pixel data and vsync on pclk; vsync is resynchronised, pixel data is not.
 */
// Decided for this implementation: the APB slave port and the address map.
`include "sig_analyzer_regs.svh"

// Contract
// - the signature is a 16-bit register advanced by the polynomial x16+x12+x5+1.
// - bits 1:0 pick the byte used: 0 red, 1 green, 2 blue of the 24-bit pixel; 3 gives a zero byte.
// - bit 3 of the control register is the enable/stop bit.
// - bit 2 of the control register is the reset/normal bit.
// - bits 31:16 of the register read back the current signature and ignore writes.
// - arming a run clears the signature to zero before any data is taken.
// - accumulation starts on the first rising vsync edge after arming.
// - that same vsync edge clears bit 2 by hardware.
// - the next rising vsync edge stops accumulation, clears bit 3 and freezes the signature.
module frame_signature_analyzer
    import sig_analyzer_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire pixel_in_t   pix,
    output logic             run_busy
);

    sig_regs_t r_r;
    sig_regs_t r_nxt;

    // ----------------------------------------------------------------
    // reset image of the state
    // ----------------------------------------------------------------
    localparam sig_regs_t regs_rst = '{
        state:   ST_IDLE,
        sel:     2'b00,
        sig:     `SIG_SEED,
        default: '0
    };

    // ----------------------------------------------------------------
    // crc step, msb first
    // ----------------------------------------------------------------
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        logic        fb;
        x = c;
        for (int i = 7; i >= 0; i--) begin
            fb = x[15] ^ d[i];
            x  = {x[14:0], 1'b0} ^ (fb ? `SIG_POLY : 16'h0000);
        end
        return x;
    endfunction

    // ----------------------------------------------------------------
    // helper nets
    // ----------------------------------------------------------------
    logic [7:0]  comp;
    logic        vs_rise;
    logic        setup_ph;
    logic        access_ph;
    logic        acc_wr;
    logic        hit;
    logic        lane0;
    logic        arm_req;
    logic        stop_req;
    logic        crc_step;
    logic [15:0] crc_next;
    logic [31:0] rd_word;
    logic        en_bit;
    logic        clr_bit;
    logic        rsp_ready;
    logic        rsp_err;
    logic [31:0] rsp_data;

    // ----------------------------------------------------------------
    // component select
    // ----------------------------------------------------------------
    always_comb begin
        unique case (r_r.sel)
            2'b00: begin
                comp = pix.red;
            end
            2'b01: begin
                comp = pix.green;
            end
            2'b10: begin
                comp = pix.blue;
            end
            default: begin
                comp = 8'h00;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    always_comb begin
        hit       = (paddr == `SIG_CTRL_OFFSET);
        setup_ph  = psel & ~penable;
        access_ph = psel & penable;
        lane0     = pstrb[0];
        acc_wr    = access_ph & r_r.pready & pwrite & hit & lane0;
        arm_req   = acc_wr & pwdata[`SIG_EN_BIT] & pwdata[`SIG_CLR_BIT];
        stop_req  = acc_wr & ~pwdata[`SIG_EN_BIT];
    end

    // ----------------------------------------------------------------
    // status word
    // ----------------------------------------------------------------
    always_comb begin
        en_bit  = (r_r.state != ST_IDLE);
        clr_bit = (r_r.state == ST_ARMED);
        rd_word = 32'h0000_0000;
        rd_word[`SIG_VAL_LSB +: 16] = r_r.sig;
        rd_word[`SIG_EN_BIT]        = en_bit;
        rd_word[`SIG_CLR_BIT]       = clr_bit;
        rd_word[`SIG_SEL_LSB +: 2]  = r_r.sel;
    end

    // ----------------------------------------------------------------
    // vsync edge and crc step
    // ----------------------------------------------------------------
    always_comb begin
        // the byte of the edge-detect cycle is left out
        vs_rise  = r_r.vs_sync & ~r_r.vs_prev;
        crc_step = (r_r.state == ST_RUN) & ~vs_rise & pix.valid;
        crc_next = crc_byte(r_r.sig, comp);
    end

    // ----------------------------------------------------------------
    // bus response
    // ----------------------------------------------------------------
    always_comb begin
        // answer in the cycle after setup, no wait states
        rsp_ready = setup_ph;
        rsp_err   = setup_ph & ~hit;
        rsp_data  = 32'h0000_0000;
        if (setup_ph & ~pwrite & hit) begin
            rsp_data = rd_word;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        r_nxt = r_r;

        // vsync passes two flops before the edge detector reads it
        r_nxt.vs_meta = pix.vsync;
        r_nxt.vs_sync = r_r.vs_meta;
        r_nxt.vs_prev = r_r.vs_sync;

        unique case (r_r.state)
            ST_IDLE: begin
                r_nxt.state = ST_IDLE;
            end
            ST_ARMED: begin
                if (vs_rise) begin
                    r_nxt.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (vs_rise) begin
                    r_nxt.state = ST_IDLE;
                end
            end
        endcase

        if (crc_step) begin
            r_nxt.sig = crc_next;
        end

        // an arm or stop write wins over a vsync edge in the same cycle
        if (acc_wr) begin
            r_nxt.sel = pwdata[`SIG_SEL_LSB +: 2];
        end
        if (arm_req) begin
            r_nxt.state = ST_ARMED;
            r_nxt.sig   = `SIG_SEED;
        end else if (stop_req) begin
            r_nxt.state = ST_IDLE;
        end

        r_nxt.busy = (r_nxt.state != ST_IDLE);

        r_nxt.pready  = rsp_ready;
        r_nxt.pslverr = rsp_err;
        r_nxt.prdata  = rsp_data;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_r <= regs_rst;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata   = r_r.prdata;
    assign pready   = r_r.pready;
    assign pslverr  = r_r.pslverr;
    assign run_busy = r_r.busy;

endmodule

// ==== common/sig_analyzer_regs.svh ====
/*
 * register offsets, field positions, reset values and polynomial of the signature analyzer.
 * assumes inclusion by bare name from the package and the design.
 */
`ifndef SIG_ANALYZER_REGS_SVH
`define SIG_ANALYZER_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SIG_CTRL_OFFSET   12'h000
`define SIG_CTRL_RESET    32'h0000_0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SIG_SEL_LSB       0
`define SIG_CLR_BIT       2
`define SIG_EN_BIT        3
`define SIG_VAL_LSB       16

// ----------------------------------------------------------------
// crc
// ----------------------------------------------------------------
`define SIG_POLY          16'h1021
`define SIG_SEED          16'h0000

`endif

// ==== common/sig_analyzer_pkg.sv ====
/*
 * types of the signature analyzer.
 * assumes sig_analyzer_regs.svh on the include path.
 */
package sig_analyzer_pkg;
    `include "sig_analyzer_regs.svh"

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUN   = 3'b100
    } sig_state_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic       valid;
        logic       vsync;
    } pixel_in_t;

    typedef struct packed {
        sig_state_t  state;
        logic [1:0]  sel;
        logic [15:0] sig;
        logic        vs_meta;
        logic        vs_sync;
        logic        vs_prev;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        busy;
    } sig_regs_t;
endpackage

// ==== dv/fsa_chk.sv ====
/* port checker of the signature analyzer; bound to the design top below */
module fsa_chk (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        run_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_ok;
    assign wr_ok = pready && pwrite && paddr == 12'h000 && pstrb[0];
    setup_rdy_a: assert property (psel && !penable |=> pready) else $error("no ready");
    rdy_only_a: assert property (!(psel && !penable) |=> !pready) else $error("stray ready");
    err_addr_a: assert property (pready |-> pslverr == (paddr != 12'h000)) else $error("err");
    data_zero_a: assert property (!pready || pslverr |-> prdata == 32'h0000_0000)
        else $error("data leak");
    arm_busy_a: assert property (wr_ok && pwdata[3:2] == 2'b11 |=> run_busy)
        else $error("no arm");
    run_stop_a: assert property (wr_ok && !pwdata[3] |=> !run_busy) else $error("no stop");
    lane_mask_a: assert property (pready && pwrite && !pstrb[0] && !run_busy |=> !run_busy)
        else $error("lane");
    busy_src_a: assert property ($rose(run_busy) |-> $past(wr_ok)) else $error("self arm");
    cover property (pready && pslverr);
    cover property ($fell(run_busy));
    cover property (wr_ok && pwdata[3:2] == 2'b11);
endmodule
bind frame_signature_analyzer fsa_chk fsa_chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .run_busy);

// ==== dv/pix_src.sv ====
/* pixel pipeline model; frame() is called by the bench just after a pclk edge */
module pix_src
    import sig_analyzer_pkg::*;
(
    input  wire logic pclk,
    output pixel_in_t pix
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       v = 1'b0;
    logic       vs = 1'b0;
    logic [7:0] d = 8'h00;
    logic [7:0] t = 8'h00;
    always @(posedge pclk) t <= t + 8'h01;
    // colours churn while no pixel is valid
    assign pix = {v ? d : t, v ? d ^ 8'h5a : ~t, v ? ~d : t ^ 8'h33, v, vs};
    task automatic frame(input int n);
        vs <= 1'b1;
        repeat (2) @(posedge pclk);
        vs <= 1'b0;
        repeat (6) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            v <= 1'b1;
            d <= i[7:0];
            @(posedge pclk);
        end
        v <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
endmodule

// ==== dv/test_frame_signature_analyzer.sv ====
/* testbench of the signature analyzer; assumes pix_src and fsa_chk compiled first */
module test_frame_signature_analyzer;
    import sig_analyzer_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, run_busy, e;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [3:0]  pstrb = '0;
    pixel_in_t   pix;
    int          fail_count = 0, num_checks = 0, cyc = 0;
    always #12.5 pclk = ~pclk;
    frame_signature_analyzer frame_signature_analyzer_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pix, .run_busy);
    pix_src pix_src_i (.pclk, .pix);
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge pclk) if (++cyc == 5000) begin
        fail_count++;
        wrap_up();
    end
    task automatic chk(input logic [31:0] g, x);
        num_checks++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {b, 8'h00};
        for (int k = 0; k < 8; k++) c = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    task automatic t_regs();
        apb(0, 12'h000, 0, 0);
        chk(r, 32'h0000_0000);
        apb(1, 12'h004, 32'h0000_000c, 4'hf);
        chk({r[31:1], e}, 32'h0000_0001);
        apb(1, 12'h000, 32'h0000_000c, 4'he);
        @(posedge pclk) chk({31'h0000_0000, run_busy}, 0);
        apb(1, 12'h000, 32'h0000_000c, 4'hf);
        @(posedge pclk) chk({31'h0000_0000, run_busy}, 32'h0000_0001);
        apb(1, 12'h000, 32'h0000_0000, 4'hf);
        @(posedge pclk) chk({31'h0000_0000, run_busy}, 0);
    endtask
    task automatic t_run(input logic [1:0] s);
        logic [15:0] x;
        logic [7:0]  b;
        x = 16'h0000;
        apb(1, 12'h000, {16'hffff, 12'h000, 2'b11, s}, 4'hf);
        apb(0, 12'h000, 0, 0);
        chk(r, {28'h000_0000, 2'b11, s});
        pix_src_i.frame(20);
        apb(0, 12'h000, 0, 0);
        chk(r & 32'h0000_000c, 32'h0000_0008);
        for (int i = 0; i < 20; i++) begin
            b = (s == 2'h0) ? i[7:0] : (s == 2'h1) ? i[7:0] ^ 8'h5a :
                (s == 2'h2) ? ~i[7:0] : 8'h00;
            x = crc(x, b);
        end
        pix_src_i.frame(0);
        apb(0, 12'h000, 0, 0);
        chk(r, {x, 14'h0000, s});
        pix_src_i.frame(5);
        apb(0, 12'h000, 0, 0);
        chk(r, {x, 14'h0000, s});
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        for (int s = 0; s < 4; s++) t_run(s[1:0]);
        wrap_up();
    end
endmodule
